// ---- verilog/dlmc_pkg.sv ----
// Shared constants for the deframer lane mode configuration ends
package dlmc_pkg;
   // Device register offsets on the configuration channel
   localparam logic [11:0] OFF_STATUS = 12'h030;
   localparam logic [11:0] OFF_LANES = 12'h453;
   localparam logic [11:0] OFF_OCT_M1 = 12'h454;
   localparam logic [11:0] OFF_FRAMES = 12'h455;
   localparam logic [11:0] OFF_CONV = 12'h456;
   localparam logic [11:0] OFF_RES = 12'h457;
   localparam logic [11:0] OFF_SUBNP = 12'h458;
   localparam logic [11:0] OFF_VERS = 12'h459;
   localparam logic [11:0] OFF_DENS = 12'h45A;
   localparam logic [11:0] OFF_DESKEW = 12'h46C;
   localparam logic [11:0] OFF_OCT_TRUE = 12'h476;
   localparam logic [11:0] OFF_LANE_EN = 12'h47D;
   // Field positions
   localparam int SCRAMBLE_BIT = 7;
   localparam int DENSITY_BIT = 7;
   localparam int CFG_ERR_BIT = 3;
   localparam int COUNT_MSB = 4;
   localparam int TOP_LSB = 5;
   // Reset value of every configuration register
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Field values used by the controller
   localparam logic [7:0] RES_16BIT = 8'h0F;
   localparam logic [7:0] NP_16BIT = 8'h0F;
   localparam logic [2:0] VERSION_B = 3'h1;
   localparam logic [7:0] K_16 = 8'h0F;
   localparam logic [7:0] K_32 = 8'h1F;
   localparam logic [7:0] HD_SET = 8'h80;
   localparam logic [7:0] HD_CLEAR = 8'h00;
   localparam logic [7:0] MASK_4LANE = 8'h0F;
   localparam logic [7:0] MASK_2LANE = 8'h03;
   // Controller register byte offsets on Wishbone
   localparam logic [3:0] WB_CTRL = 4'h0;
   localparam logic [3:0] WB_STATUS = 4'h4;
   // Controller control fields
   localparam int CTRL_START = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_SCR = 3;
   localparam int CTRL_SUB1 = 4;
   localparam int CTRL_K32 = 5;
   // Controller mode selections
   localparam logic [1:0] SEL_MODE4 = 2'h0;
   localparam logic [1:0] SEL_MODE5 = 2'h1;
   localparam logic [1:0] SEL_MODE6 = 2'h2;
   // Index of the last step, the status read, in the programming sequence
   localparam logic [3:0] LAST_STEP = 4'hB;
   // Reported mode numbers
   localparam logic [3:0] MODE_NONE = 4'h0;
endpackage

// ---- verilog/dlmc_if.sv ----
// Configuration channel between controller and deframer register bank
interface dlmc_if;
   logic req;
   logic we;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   modport host (output req, output we, output addr, output wdata, input rdata, input ack);
   modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface

// ---- verilog/dlmc_mode_check.sv ----
// Decodes link parameters into a supported mode number or an error
module dlmc_mode_check (
   input wire logic [4:0] lanes_m1_i,
   input wire logic [7:0] conv_m1_i,
   input wire logic [7:0] oct_m1_i,
   input wire logic [4:0] samp_m1_i,
   output logic [3:0] mode_o,
   output logic unsupported_o
);
   // Match lane, converter, octet and sample counts against the mode table
   always_comb begin
      mode_o = dlmc_pkg::MODE_NONE;
      unique case ({lanes_m1_i, conv_m1_i, oct_m1_i, samp_m1_i})
         {5'h03, 8'h01, 8'h00, 5'h00}: mode_o = 4'h4;
         {5'h03, 8'h01, 8'h01, 5'h01}: mode_o = 4'h5;
         {5'h01, 8'h01, 8'h01, 5'h00}: mode_o = 4'h6;
         {5'h00, 8'h01, 8'h03, 5'h00}: mode_o = 4'h7;
         {5'h01, 8'h00, 8'h00, 5'h00}: mode_o = 4'h9;
         {5'h00, 8'h00, 8'h01, 5'h00}: mode_o = 4'hA;
         default: mode_o = dlmc_pkg::MODE_NONE;
      endcase
      unsupported_o = (mode_o == dlmc_pkg::MODE_NONE);
   end
endmodule // dlmc_mode_check

// ---- verilog/dlmc_dev.sv ----
// Deframer lane mode configuration register bank, device end
// Notes on behaviour
// - Host configures, then deskews, then enables lanes
// - Deskew mask bit x deskews lane x
// - Enable mask bit x enables lane x
// - Lane-count bit 7 enables descrambling
// - Lane-count bits 4:0 hold lanes minus one
// - Octets register holds octets minus one
// - Multiframe bits 4:0 hold frames minus one
// - Converter register holds converters minus one
// - Host keeps resolution bits 7:6 zero
// - Host sets resolution field to fifteen
// - Bits 7:5 select subclass
// - Bits 4:0 hold bits per sample minus one
// - Bits 7:5 encode link version
// - Density bit 7 selects high density
// - Host writes zero control words field
// - Separate register holds true octet count
// - Mode 4 host settings
// - Mode 5 host settings
// - Mode 6 host settings
// - One enable bit per lane
// - Single link modes 4 to 10, not 8
// - Flag unsupported lane/converter/octet/sample combination
//
// The Wishbone slave port was left to the implementer.

module dlmc_dev #(
   parameter int LANES = 4,
   parameter int OCTET = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   dlmc_if.dev cfg,
   input wire logic [LANES*OCTET-1:0] lane_data_i,
   output logic [LANES*OCTET-1:0] lane_data_o,
   output logic [LANES-1:0] lane_capture_o,
   output logic descramble_en_o,
   output logic [4:0] lanes_m1_o,
   output logic [7:0] octets_m1_o,
   output logic [7:0] octets_o,
   output logic [4:0] frames_m1_o,
   output logic [7:0] conv_m1_o,
   output logic [2:0] subclass_o,
   output logic [4:0] np_m1_o,
   output logic [2:0] version_o,
   output logic [4:0] samples_m1_o,
   output logic high_density_o,
   output logic [7:0] deskew_mask_o,
   output logic [7:0] lane_enable_o,
   output logic [3:0] mode_o,
   output logic cfg_error_o
);
   // Configuration register bytes, one flop set each
   logic [7:0] lanes_q;
   logic [7:0] oct_m1_q;
   logic [7:0] frames_q;
   logic [7:0] conv_q;
   logic [7:0] res_q;
   logic [7:0] subnp_q;
   logic [7:0] vers_q;
   logic [7:0] dens_q;
   logic [7:0] deskew_q;
   logic [7:0] oct_true_q;
   logic [7:0] lane_en_q;
   // Channel answer and decoded state
   logic [7:0] rdata_q;
   logic ack_q;
   logic [3:0] mode_w;
   logic unsup_w;
   logic [3:0] mode_q;
   logic err_q;
   // Lane pipeline and capture flags
   logic [LANES*OCTET-1:0] data_q;
   logic [LANES-1:0] cap_q;
   logic wr;

   // Write strobe; a request still high in its ack cycle is not taken twice
   assign wr = cfg.req & cfg.we & ~ack_q;

   // Configuration register writes
   // Unmapped offsets and the read-only status byte are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lanes_q <= dlmc_pkg::CFG_RESET;
         oct_m1_q <= dlmc_pkg::CFG_RESET;
         frames_q <= dlmc_pkg::CFG_RESET;
         conv_q <= dlmc_pkg::CFG_RESET;
         res_q <= dlmc_pkg::CFG_RESET;
         subnp_q <= dlmc_pkg::CFG_RESET;
         vers_q <= dlmc_pkg::CFG_RESET;
         dens_q <= dlmc_pkg::CFG_RESET;
         deskew_q <= dlmc_pkg::CFG_RESET;
         oct_true_q <= dlmc_pkg::CFG_RESET;
         lane_en_q <= dlmc_pkg::CFG_RESET;
      end else if (wr) begin
         unique case (cfg.addr)
            dlmc_pkg::OFF_LANES: lanes_q <= cfg.wdata;
            dlmc_pkg::OFF_OCT_M1: oct_m1_q <= cfg.wdata;
            dlmc_pkg::OFF_FRAMES: frames_q <= cfg.wdata;
            dlmc_pkg::OFF_CONV: conv_q <= cfg.wdata;
            dlmc_pkg::OFF_RES: res_q <= cfg.wdata;
            dlmc_pkg::OFF_SUBNP: subnp_q <= cfg.wdata;
            dlmc_pkg::OFF_VERS: vers_q <= cfg.wdata;
            dlmc_pkg::OFF_DENS: dens_q <= cfg.wdata;
            dlmc_pkg::OFF_DESKEW: deskew_q <= cfg.wdata;
            dlmc_pkg::OFF_OCT_TRUE: oct_true_q <= cfg.wdata;
            dlmc_pkg::OFF_LANE_EN: lane_en_q <= cfg.wdata;
            default: ;
         endcase
      end
   end

   // Read back and one-cycle acknowledge
   // Read data holds until the next accepted request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= cfg.req & ~ack_q;
         if (cfg.req & ~ack_q) begin
            unique case (cfg.addr)
               dlmc_pkg::OFF_STATUS: rdata_q <= 8'(err_q) << dlmc_pkg::CFG_ERR_BIT;
               dlmc_pkg::OFF_LANES: rdata_q <= lanes_q;
               dlmc_pkg::OFF_OCT_M1: rdata_q <= oct_m1_q;
               dlmc_pkg::OFF_FRAMES: rdata_q <= frames_q;
               dlmc_pkg::OFF_CONV: rdata_q <= conv_q;
               dlmc_pkg::OFF_RES: rdata_q <= res_q;
               dlmc_pkg::OFF_SUBNP: rdata_q <= subnp_q;
               dlmc_pkg::OFF_VERS: rdata_q <= vers_q;
               dlmc_pkg::OFF_DENS: rdata_q <= dens_q;
               dlmc_pkg::OFF_DESKEW: rdata_q <= deskew_q;
               dlmc_pkg::OFF_OCT_TRUE: rdata_q <= oct_true_q;
               dlmc_pkg::OFF_LANE_EN: rdata_q <= lane_en_q;
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // Channel answer straight from the flops
   assign cfg.ack = ack_q;
   assign cfg.rdata = rdata_q;

   // Supported mode decode
   // Only L, M, F and S are compared; K, N and NP are not checked
   dlmc_mode_check u_check (
      .lanes_m1_i(lanes_q[dlmc_pkg::COUNT_MSB:0]),
      .conv_m1_i(conv_q),
      .oct_m1_i(oct_m1_q),
      .samp_m1_i(vers_q[dlmc_pkg::COUNT_MSB:0]),
      .mode_o(mode_w),
      .unsupported_o(unsup_w)
   );

   // Registered mode and configuration error flag
   // Flag starts set: all-zero registers form no supported mode
   // It follows the decode one cycle late, like the mode number
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= dlmc_pkg::MODE_NONE;
         err_q <= 1'b1;
      end else begin
         mode_q <= mode_w;
         err_q <= unsup_w;
      end
   end

   // Per-lane gating: capture flag needs deskew and enable, data passes on enable alone
   // A disabled lane reads as zero instead of holding stale data
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cap_q[g] <= 1'b0;
               data_q[g*OCTET +: OCTET] <= '0;
            end else begin
               cap_q[g] <= lane_en_q[g] & deskew_q[g];
               data_q[g*OCTET +: OCTET] <= lane_en_q[g] ? lane_data_i[g*OCTET +: OCTET] : '0;
            end
         end
      end
   endgenerate

   // Lane outputs
   assign lane_data_o = data_q;
   assign lane_capture_o = cap_q;

   // Link parameter fields straight from the register flops
   assign descramble_en_o = lanes_q[dlmc_pkg::SCRAMBLE_BIT];
   assign lanes_m1_o = lanes_q[dlmc_pkg::COUNT_MSB:0];
   assign octets_m1_o = oct_m1_q;
   assign octets_o = oct_true_q;
   assign frames_m1_o = frames_q[dlmc_pkg::COUNT_MSB:0];
   assign conv_m1_o = conv_q;
   assign subclass_o = subnp_q[7:dlmc_pkg::TOP_LSB];
   assign np_m1_o = subnp_q[dlmc_pkg::COUNT_MSB:0];
   assign version_o = vers_q[7:dlmc_pkg::TOP_LSB];
   assign samples_m1_o = vers_q[dlmc_pkg::COUNT_MSB:0];
   assign high_density_o = dens_q[dlmc_pkg::DENSITY_BIT];

   // Lane masks, decoded mode and error flag
   assign deskew_mask_o = deskew_q;
   assign lane_enable_o = lane_en_q;
   assign mode_o = mode_q;
   assign cfg_error_o = err_q;
endmodule // dlmc_dev

// ---- verilog/dlmc_host.sv ----
// Controller that programs the deframer for modes 4, 5 and 6
module dlmc_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   dlmc_if.host cfg
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_REQ = 2'b01
   } dlmc_hstate_t;

   dlmc_hstate_t st_q;
   logic [3:0] step_q;
   logic [1:0] mode_q;
   logic scr_q, sub_q, k32_q, done_q, err_q, bad_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic req_q, we_q;
   logic [11:0] addr_q;
   logic [7:0] wdata_q;
   logic wb_hit, start;

   // Address of each step: parameters, then deskew, then enable, then status
   function automatic logic [11:0] step_addr(input logic [3:0] s);
      unique case (s)
         4'h0: step_addr = dlmc_pkg::OFF_LANES;
         4'h1: step_addr = dlmc_pkg::OFF_OCT_M1;
         4'h2: step_addr = dlmc_pkg::OFF_FRAMES;
         4'h3: step_addr = dlmc_pkg::OFF_CONV;
         4'h4: step_addr = dlmc_pkg::OFF_RES;
         4'h5: step_addr = dlmc_pkg::OFF_SUBNP;
         4'h6: step_addr = dlmc_pkg::OFF_VERS;
         4'h7: step_addr = dlmc_pkg::OFF_DENS;
         4'h8: step_addr = dlmc_pkg::OFF_OCT_TRUE;
         4'h9: step_addr = dlmc_pkg::OFF_DESKEW;
         4'hA: step_addr = dlmc_pkg::OFF_LANE_EN;
         default: step_addr = dlmc_pkg::OFF_STATUS;
      endcase
   endfunction

   // Value of each step for the selected mode
   function automatic logic [7:0] step_data(input logic [3:0] s, input logic [1:0] m,
                                            input logic scr, input logic sub, input logic k32);
      logic m4, m6;
      m4 = (m == dlmc_pkg::SEL_MODE4);
      m6 = (m == dlmc_pkg::SEL_MODE6);
      unique case (s)
         4'h0: step_data = {scr, 2'b00, m6 ? 5'h01 : 5'h03};
         4'h1: step_data = m4 ? 8'h00 : 8'h01;
         4'h2: step_data = (m4 | k32) ? dlmc_pkg::K_32 : dlmc_pkg::K_16;
         4'h3: step_data = 8'h01;
         4'h4: step_data = dlmc_pkg::RES_16BIT;
         4'h5: step_data = {2'b00, sub, dlmc_pkg::NP_16BIT[4:0]};
         4'h6: step_data = {dlmc_pkg::VERSION_B, (m == dlmc_pkg::SEL_MODE5) ? 5'h01 : 5'h00};
         4'h7: step_data = m4 ? dlmc_pkg::HD_SET : dlmc_pkg::HD_CLEAR;
         4'h8: step_data = m4 ? 8'h01 : 8'h02;
         4'h9: step_data = m6 ? dlmc_pkg::MASK_2LANE : dlmc_pkg::MASK_4LANE;
         4'hA: step_data = m6 ? dlmc_pkg::MASK_2LANE : dlmc_pkg::MASK_4LANE;
         default: step_data = 8'h00;
      endcase
   endfunction

   assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
   assign start = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == dlmc_pkg::WB_CTRL)
                  & wb_dat_i[dlmc_pkg::CTRL_START] & (st_q == H_IDLE);

   // Wishbone slave: ack one cycle after the strobe, reads of own registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_hit;
         if (wb_hit & ~wb_we_i) begin
            unique case (wb_adr_i)
               dlmc_pkg::WB_CTRL: dat_q <= {26'h0, k32_q, sub_q, scr_q, mode_q, 1'b0};
               dlmc_pkg::WB_STATUS: dat_q <= {28'h0, bad_q, err_q, done_q, st_q != H_IDLE};
               default: dat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Programming sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= H_IDLE;
         step_q <= 4'h0;
         mode_q <= dlmc_pkg::SEL_MODE4;
         scr_q <= 1'b0;
         sub_q <= 1'b0;
         k32_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         bad_q <= 1'b0;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 12'h000;
         wdata_q <= 8'h00;
      end else begin
         unique case (st_q)
            H_IDLE: begin
               if (wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == dlmc_pkg::WB_CTRL)) begin
                  mode_q <= wb_dat_i[dlmc_pkg::CTRL_MODE_LSB +: 2];
                  scr_q <= wb_dat_i[dlmc_pkg::CTRL_SCR];
                  sub_q <= wb_dat_i[dlmc_pkg::CTRL_SUB1];
                  k32_q <= wb_dat_i[dlmc_pkg::CTRL_K32];
               end
               if (start) begin
                  done_q <= 1'b0;
                  bad_q <= (wb_dat_i[dlmc_pkg::CTRL_MODE_LSB +: 2] == 2'h3);
                  if (wb_dat_i[dlmc_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
                     st_q <= H_REQ;
                     step_q <= 4'h0;
                     req_q <= 1'b1;
                     we_q <= 1'b1;
                     addr_q <= step_addr(4'h0);
                     wdata_q <= step_data(4'h0, wb_dat_i[dlmc_pkg::CTRL_MODE_LSB +: 2],
                                          wb_dat_i[dlmc_pkg::CTRL_SCR],
                                          wb_dat_i[dlmc_pkg::CTRL_SUB1],
                                          wb_dat_i[dlmc_pkg::CTRL_K32]);
                  end else begin
                     done_q <= 1'b1;
                  end
               end
            end
            H_REQ: begin
               if (cfg.ack & req_q) begin
                  req_q <= 1'b0;
                  if (step_q == dlmc_pkg::LAST_STEP) begin
                     err_q <= cfg.rdata[dlmc_pkg::CFG_ERR_BIT];
                     done_q <= 1'b1;
                     st_q <= H_IDLE;
                  end else begin
                     step_q <= step_q + 4'h1;
                  end
               end else if (~req_q & ~cfg.ack) begin
                  req_q <= 1'b1;
                  we_q <= (step_q != dlmc_pkg::LAST_STEP);
                  addr_q <= step_addr(step_q);
                  wdata_q <= step_data(step_q, mode_q, scr_q, sub_q, k32_q);
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   assign cfg.req = req_q;
   assign cfg.we = we_q;
   assign cfg.addr = addr_q;
   assign cfg.wdata = wdata_q;
endmodule // dlmc_host

// ---- verif/dlmc_properties.sv ----
// Protocol and programming order checks on the configuration channel
module dlmc_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req,
   input wire logic we,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] oct_m1_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Last octets-minus-one value sent to the device
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oct_m1_q <= 8'h00;
      end else if (req && we && !ack && addr == dlmc_pkg::OFF_OCT_M1) begin
         oct_m1_q <= wdata;
      end
   end

   ack_answer_a: assert property (req && !ack |=> ack)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack |-> $past(req))
      else $error("ack without request");
   req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
      else $error("request changed before ack");
   req_drop_a: assert property (ack |=> !req)
      else $error("request kept after ack");
   lane_then_oct_a: assert property (ack && we && addr == dlmc_pkg::OFF_LANES
      |=> ##[1:3] (req && we && addr == dlmc_pkg::OFF_OCT_M1))
      else $error("octet write does not follow lane write");
   deskew_first_a: assert property (ack && we && addr == dlmc_pkg::OFF_DESKEW
      |=> ##[1:3] (req && we && addr == dlmc_pkg::OFF_LANE_EN))
      else $error("enable write does not follow deskew write");
   status_read_a: assert property (ack && we && addr == dlmc_pkg::OFF_LANE_EN
      |=> ##[1:3] (req && !we && addr == dlmc_pkg::OFF_STATUS))
      else $error("status not read after enabling lanes");
   res_value_a: assert property (req && we && addr == dlmc_pkg::OFF_RES |-> wdata == 8'h0F)
      else $error("resolution byte wrong");
   density_byte_a: assert property (req && we && addr == dlmc_pkg::OFF_DENS
      |-> wdata[4:0] == 5'h00 && wdata[7] == (oct_m1_q == 8'h00))
      else $error("density byte wrong");
   oct_true_a: assert property (req && we && addr == dlmc_pkg::OFF_OCT_TRUE
      |-> wdata == oct_m1_q + 8'h01)
      else $error("true octet count disagrees with octets minus one");
endmodule // dlmc_properties

// ---- verif/dlmc_tb.sv ----
// Self-checking bench joining controller and device over the channel
module dlmc_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat_w = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic [31:0] lane_data_i = 32'h0;
   logic [31:0] lane_data_o;
   logic [3:0] lane_capture_o;
   logic descramble_en_o;
   logic high_density_o;
   logic cfg_error_o;
   logic [4:0] lanes_m1_o, frames_m1_o, np_m1_o, samples_m1_o;
   logic [7:0] octets_m1_o, octets_o, conv_m1_o, deskew_mask_o, lane_enable_o;
   logic [2:0] subclass_o, version_o;
   logic [3:0] mode_o;
   int err_total = 0;
   int cmp_count = 0;

   dlmc_if dlmc_if_i ();
   dlmc_host dlmc_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .cfg(dlmc_if_i.host));
   dlmc_dev #(.LANES(4), .OCTET(8)) dlmc_dev_i (.clk_i(clk_i), .rst_i(rst_i),
      .cfg(dlmc_if_i.dev), .lane_data_i(lane_data_i), .lane_data_o(lane_data_o),
      .lane_capture_o(lane_capture_o), .descramble_en_o(descramble_en_o),
      .lanes_m1_o(lanes_m1_o), .octets_m1_o(octets_m1_o), .octets_o(octets_o),
      .frames_m1_o(frames_m1_o), .conv_m1_o(conv_m1_o), .subclass_o(subclass_o),
      .np_m1_o(np_m1_o), .version_o(version_o), .samples_m1_o(samples_m1_o),
      .high_density_o(high_density_o), .deskew_mask_o(deskew_mask_o),
      .lane_enable_o(lane_enable_o), .mode_o(mode_o), .cfg_error_o(cfg_error_o));
   dlmc_properties dlmc_properties_i (.clk_i(clk_i), .rst_i(rst_i), .req(dlmc_if_i.req),
      .we(dlmc_if_i.we), .addr(dlmc_if_i.addr), .wdata(dlmc_if_i.wdata),
      .rdata(dlmc_if_i.rdata), .ack(dlmc_if_i.ack));

   // Clock, 50 ns period
   always #25 clk_i = ~clk_i;

   // Verdict and end of run
   task automatic close_out();
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_sel <= 4'hF;
      wb_adr <= a;
      wb_dat_w <= d;
      n = 0;
      while (n < 20) begin
         @(posedge clk_i);
         n++;
         if (wb_ack === 1'b1) break;
      end
      r = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      wb_sel <= 4'h0;
      if (wb_ack !== 1'b1) begin
         err_total++;
         close_out();
      end
   endtask

   // Start the controller and poll until idle and done
   task automatic prog(input logic [31:0] ctrl, input logic [31:0] second);
      logic [31:0] r;
      int n;
      wb_xfer(1'b1, dlmc_pkg::WB_CTRL, ctrl, r);
      wb_xfer(1'b1, dlmc_pkg::WB_CTRL, second, r);
      r = 32'h1;
      n = 0;
      while (n < 40 && r[1:0] !== 2'b10) begin
         wb_xfer(1'b0, dlmc_pkg::WB_STATUS, 32'h0, r);
         n++;
      end
      if (r[1:0] !== 2'b10) begin
         err_total++;
         close_out();
      end
   endtask

   // Device fields against expected register bytes
   task automatic fields(input logic [7:0] e [0:9], input logic [3:0] m);
      logic [31:0] r;
      check("lanes", {descramble_en_o, 2'b00, lanes_m1_o}, e[0]);
      check("oct_m1", octets_m1_o, e[1]);
      check("frames", frames_m1_o, e[2]);
      check("conv", conv_m1_o, e[3]);
      check("np", {subclass_o, np_m1_o}, e[4]);
      check("samples", {version_o, samples_m1_o}, e[5]);
      check("density", {high_density_o, 7'h00}, e[6]);
      check("deskew", deskew_mask_o, e[7]);
      check("octets", octets_o, e[8]);
      check("enable", lane_enable_o, e[9]);
      check("capture", lane_capture_o, e[7][3:0] & e[9][3:0]);
      check("mode", mode_o, m);
      check("cfg_err", cfg_error_o, 1'b0);
      wb_xfer(1'b0, dlmc_pkg::WB_STATUS, 32'h0, r);
      check("status", r, 32'h2);
   endtask

   // Reset state and unmapped read
   task automatic sc_reset();
      logic [31:0] r;
      check("cfg_err", cfg_error_o, 1'b1);
      check("mode", mode_o, 4'h0);
      check("capture", lane_capture_o, 4'h0);
      wb_xfer(1'b0, dlmc_pkg::WB_STATUS, 32'h0, r);
      check("status", r, 32'h0);
      wb_xfer(1'b0, 4'h8, 32'h0, r);
      check("unmapped", r, 32'h0);
   endtask

   // Mode 4, scrambled, subclass 1, multiframe length forced
   task automatic sc_mode4();
      prog(32'h19, 32'h19);
      fields('{8'h83, 8'h00, 8'h1F, 8'h01, 8'h2F, 8'h20, 8'h80, 8'h0F, 8'h01, 8'h0F},
             4'h4);
   endtask

   // Mode 5, short multiframe, second start while busy ignored
   task automatic sc_mode5();
      logic [31:0] r;
      prog(32'h03, 32'h19);
      fields('{8'h03, 8'h01, 8'h0F, 8'h01, 8'h0F, 8'h21, 8'h00, 8'h0F, 8'h02, 8'h0F},
             4'h5);
      wb_xfer(1'b0, dlmc_pkg::WB_CTRL, 32'h0, r);
      check("ctrl", r, 32'h02);
   endtask

   // Mode 6 and gating of lanes left disabled
   task automatic sc_mode6();
      prog(32'h25, 32'h25);
      fields('{8'h01, 8'h01, 8'h1F, 8'h01, 8'h0F, 8'h20, 8'h00, 8'h03, 8'h02, 8'h03},
             4'h6);
      lane_data_i <= 32'hA1B2C3D4;
      repeat (2) @(posedge clk_i);
      check("lane_data", lane_data_o, 32'h0000C3D4);
   endtask

   // Invalid mode selection sends nothing
   task automatic sc_badmode();
      logic [31:0] r;
      prog(32'h07, 32'h07);
      wb_xfer(1'b0, dlmc_pkg::WB_STATUS, 32'h0, r);
      check("status", r, 32'h0A);
      check("mode", mode_o, 4'h6);
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      sc_reset();
      sc_mode4();
      sc_mode5();
      sc_mode6();
      sc_badmode();
      close_out();
   end
endmodule // dlmc_tb
